//--- hdl/and_imm_branch_eq_exec.sv
// Execute stage for AND-high-immediate, AND-immediate and branch-equal
// Assumes operands were read from the register file by the issuing stage
// Functional notes
// - Opcode 2c: AND register A with immediate in upper half, write B.
// - Opcode 0c: AND register A with zero-extended immediate, write B.
// - Both AND immediate forms treat the immediate as unsigned.
// - Opcode 26: if A equals B, PC+4+offset, else PC+4.
// - Branch immediate is a signed byte offset from the next instruction.
// - Taken branch to a non-word-aligned address raises misaligned exception.
`timescale 1ns/10ps
module and_imm_branch_eq_exec (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Issued instruction with operands
   input  wire exec_pkg::issue_t issue,
   // Write-back, next PC and exception
   output exec_pkg::result_t     result
);
   import exec_pkg::*;

   typedef struct packed {
      result_t res;
   } state_t;

   state_t      st_r;
   state_t      st_nxt;
   logic [5:0]  opcode;
   logic [15:0] imm_field;
   logic [31:0] seq_pc;
   logic [31:0] tgt_pc;
   logic        taken;
   logic        is_andhi;
   logic        is_andi;
   logic        is_beq;
   logic        is_other;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Sign-extend a branch offset to a full address step
   function automatic logic [31:0] sext16(input logic [15:0] v);
      sext16 = {{16{v[15]}}, v};
   endfunction : sext16

   // True when a valid instruction carries the given opcode
   function automatic logic op_hit(input logic        vld,
                                   input logic [31:0] ins,
                                   input logic [5:0]  code);
      op_hit = vld && (ins[OPC_MSB:OPC_LSB] == code);
   endfunction : op_hit

   // ****************************************************************
   // Decode
   // ****************************************************************
   // Field extraction
   assign opcode    = issue.instr[OPC_MSB:OPC_LSB];
   assign imm_field = issue.instr[IMM_MSB:IMM_LSB];
   assign seq_pc    = issue.pc + PC_STEP;
   assign tgt_pc    = seq_pc + sext16(imm_field);
   assign taken     = issue.source_reg_a == issue.reg_b_operand;

   // Opcode hits, shared by the checks below
   assign is_andhi  = op_hit(issue.valid, issue.instr, OPC_ANDHI);
   assign is_andi   = op_hit(issue.valid, issue.instr, OPC_ANDI);
   assign is_beq    = op_hit(issue.valid, issue.instr, OPC_BEQ);
   assign is_other  = issue.valid && !is_andhi && !is_andi && !is_beq;

   // ****************************************************************
   // Execute
   // ****************************************************************
   // Next-state computation
   always_comb begin
      // Pulses quiet by default; next PC holds
      st_nxt     = '0;
      st_nxt.res.wr_idx = issue.instr[REG_B_MSB:REG_B_LSB];
      st_nxt.res.next_pc = st_r.res.next_pc;
      if (issue.valid) begin
         case (opcode)
            // Mask with the immediate in the upper half
            OPC_ANDHI: begin
               st_nxt.res.wr_en   = 1'b1;
               st_nxt.res.wr_data = issue.source_reg_a &
                                    {imm_field, HALF_ZERO};
            end
            // Mask with the zero-extended immediate
            OPC_ANDI: begin
               st_nxt.res.wr_en   = 1'b1;
               st_nxt.res.wr_data = issue.source_reg_a &
                                    {HALF_ZERO, imm_field};
            end
            // Compare-equal branch
            OPC_BEQ: begin
               st_nxt.res.pc_valid = 1'b1;
               st_nxt.res.next_pc  = taken ? tgt_pc : seq_pc;
               // Misaligned taken target: trap, keep the old PC
               if (taken && tgt_pc[1:0] != ALIGN_ZERO) begin
                  st_nxt.res.misalign_exc = 1'b1;
                  st_nxt.res.bad_addr     = tgt_pc;
                  st_nxt.res.next_pc      = st_r.res.next_pc;
                  st_nxt.res.pc_valid     = 1'b0;
               end
            end
            // Other opcodes: nothing written, no branch
            default: begin
               st_nxt.res.wr_en = 1'b0;
            end
         endcase
      end
   end

   // State register
   // Async clear loads constants only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r             <= '0;
         st_r.res.next_pc <= PC_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Every result field comes straight from the state register
   assign result = st_r.res;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Checks share the core clock and reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // AND results
   a_andhi_result: assert property (
      issue.valid && opcode == OPC_ANDHI |=> result.wr_en &&
      result.wr_data == ($past(issue.source_reg_a) &
                         {$past(imm_field), 16'h0000}))
      else $error("andhi result wrong");
   a_andi_result: assert property (
      issue.valid && opcode == OPC_ANDI |=> result.wr_en &&
      result.wr_data[31:16] == 16'h0000 &&
      result.wr_data[15:0] == ($past(issue.source_reg_a[15:0]) &
                               $past(imm_field)))
      else $error("andi result wrong");
   a_andi_unsigned: assert property (
      issue.valid && opcode == OPC_ANDI && imm_field[15] |=>
      result.wr_data[31:16] == 16'h0000)
      else $error("andi immediate sign-extended");
   // Branch-equal outcomes
   a_beq_fall: assert property (
      issue.valid && opcode == OPC_BEQ && !taken |=>
      result.pc_valid && result.next_pc == $past(issue.pc) + 32'h4)
      else $error("beq fall-through PC wrong");
   a_beq_taken: assert property (
      issue.valid && opcode == OPC_BEQ && taken && tgt_pc[1:0] == 2'h0
      |=> result.pc_valid && result.next_pc == $past(issue.pc) + 32'h4 +
          {{16{$past(imm_field[15])}}, $past(imm_field)})
      else $error("beq taken PC wrong");
   a_beq_misalign: assert property (
      issue.valid && opcode == OPC_BEQ && taken && tgt_pc[1:0] != 2'h0
      |=> result.misalign_exc && !result.pc_valid)
      else $error("misaligned branch not flagged");
   a_exc_cause: assert property (
      result.misalign_exc |-> $past(opcode) == OPC_BEQ &&
      result.bad_addr[1:0] != 2'h0)
      else $error("spurious misaligned exception");
   // Write-back index
   a_wb_index: assert property (
      result.wr_en |-> result.wr_idx == $past(issue.instr[26:22]))
      else $error("write index wrong");

   // AND forms: high half, unsigned, only source of writes
   a_andhi_low: assert property (
      is_andhi |=> result.wr_data[15:0] == 16'h0000)
      else $error("andhi low half not cleared");
   a_andhi_unsigned: assert property (
      is_andhi && imm_field[15] |=>
      result.wr_data[31] == $past(issue.source_reg_a[31]))
      else $error("andhi immediate top bit lost");
   a_wr_only_and: assert property (
      result.wr_en |-> $past(is_andhi) || $past(is_andi))
      else $error("write from a non-AND instruction");
   a_andi_no_pc: assert property (
      is_andi |=> !result.pc_valid && !result.misalign_exc)
      else $error("andi touched the PC");

   // Branch-equal: fall-through, hold, exception details
   a_fall_no_exc: assert property (
      is_beq && !taken |=> !result.misalign_exc && result.pc_valid)
      else $error("untaken branch raised exception");
   a_pc_hold: assert property (
      !result.pc_valid |-> result.next_pc == $past(result.next_pc))
      else $error("next PC moved without a branch");
   a_pc_only_beq: assert property (
      result.pc_valid |-> $past(is_beq) && !result.wr_en)
      else $error("PC update from a non-branch");
   a_exc_alone: assert property (
      result.misalign_exc |-> !result.wr_en && !result.pc_valid &&
      result.next_pc == $past(result.next_pc))
      else $error("exception not exclusive");
   a_misalign_addr: assert property (
      result.misalign_exc |-> result.bad_addr ==
      $past(issue.pc) + 32'h4 +
      {{16{$past(imm_field[15])}}, $past(imm_field)})
      else $error("offending address wrong");

   // Quiet cases: idle cycles and ignored opcodes
   a_idle_quiet: assert property (
      !issue.valid |=> !result.wr_en && !result.pc_valid &&
      !result.misalign_exc)
      else $error("pulse without an instruction");
   a_other_quiet: assert property (
      is_other |=> !result.wr_en && !result.pc_valid &&
      !result.misalign_exc)
      else $error("ignored opcode produced a pulse");

   // Coverage of the main scenarios
   c_andhi: cover property (issue.valid && opcode == OPC_ANDHI);
   c_andi:  cover property (issue.valid && opcode == OPC_ANDI);
   c_taken: cover property (issue.valid && opcode == OPC_BEQ && taken);
   c_exc:   cover property (result.misalign_exc);
   c_fall:  cover property (is_beq && !taken);
endmodule : and_imm_branch_eq_exec

//--- pkg/exec_pkg.sv
// Shared constants and carriers for the AND-immediate / branch-equal unit
// Assumes a 32-bit core with 32 registers and one core clock
package exec_pkg;
   // ****************************************************************
   // Instruction fields
   // ****************************************************************
   localparam int unsigned REG_A_MSB  = 31;
   localparam int unsigned REG_A_LSB  = 27;
   localparam int unsigned REG_B_MSB  = 26;
   localparam int unsigned REG_B_LSB  = 22;
   localparam int unsigned IMM_MSB    = 21;
   localparam int unsigned IMM_LSB    = 6;
   localparam int unsigned OPC_MSB    = 5;
   localparam int unsigned OPC_LSB    = 0;
   localparam logic [5:0]  OPC_ANDHI  = 6'h2c;
   localparam logic [5:0]  OPC_ANDI   = 6'h0c;
   localparam logic [5:0]  OPC_BEQ    = 6'h26;
   localparam logic [15:0] HALF_ZERO  = 16'h0000;
   localparam logic [31:0] PC_STEP    = 32'h0000_0004;
   localparam logic [31:0] PC_RESET   = 32'h0000_0000;
   localparam logic [1:0]  ALIGN_ZERO = 2'h0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic        valid;
      logic [31:0] instr;
      logic [31:0] pc;
      logic [31:0] source_reg_a;
      logic [31:0] reg_b_operand;
   } issue_t;

   typedef struct packed {
      logic        wr_en;
      logic [4:0]  wr_idx;
      logic [31:0] wr_data;
      logic        pc_valid;
      logic [31:0] next_pc;
      logic        misalign_exc;
      logic [31:0] bad_addr;
   } result_t;
endpackage : exec_pkg

//--- verification/and_imm_branch_eq_exec_tb_top.sv
// Self-checking bench for the AND-immediate / branch-equal unit
// Assumes exec_pkg carriers and a fixed one-cycle result latency
`timescale 1ns/10ps
module and_imm_branch_eq_exec_tb_top;
   import exec_pkg::*;
   // ************************************************************
   // Harness
   // ************************************************************
   logic    clk = 1'b0;
   logic    rst_b = 1'b0;
   issue_t  issue = '0;
   result_t result;
   int      n_mismatch = 0;
   int      checks_done = 0;
   and_imm_branch_eq_exec i_dut (.clk(clk), .rst_b(rst_b), .issue(issue),
      .result(result));
   // Core clock, 100 ns period
   always #50 clk = ~clk;
   // Compare and count
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Present one instruction; returns when its result is settled
   task automatic put(logic [4:0] a, logic [4:0] b, logic [15:0] imm,
      logic [5:0] opc, logic [31:0] pc, logic [31:0] va, logic [31:0] vb);
      issue = '{1'b1, {a, b, imm, opc}, pc, va, vb};
      @(posedge clk);
      #1;
   endtask : put
   // Drop valid for one cycle
   task automatic idle();
      issue.valid = 1'b0;
      @(posedge clk);
      #1;
   endtask : idle
   // ************************************************************
   // Scenarios
   // ************************************************************
   // Both AND forms back to back, top immediate bit set
   task automatic test_and();
      put(5'h03, 5'h1b, 16'h8001, OPC_ANDHI, 32'h0, 32'hf0f0_1234, 32'h0);
      chk({31'h0, result.wr_en}, 32'h1);
      chk({27'h0, result.wr_idx}, 32'h1b);
      chk(result.wr_data, 32'h8000_0000);
      put(5'h1f, 5'h04, 16'h8ff0, OPC_ANDI, 32'h0, 32'hffff_ffff, 32'h0);
      chk({27'h0, result.wr_idx}, 32'h04);
      chk(result.wr_data, 32'h0000_8ff0);
      chk({30'h0, result.wr_en, result.pc_valid}, 32'h2);
      idle();
      chk({31'h0, result.wr_en}, 32'h0);
      chk(result.wr_data, 32'h0);
      $display("test_and done");
   endtask : test_and
   // Taken back, not taken, taken forward, misaligned target
   task automatic test_beq();
      put(5'h01, 5'h02, 16'hfff0, OPC_BEQ, 32'h1000, 32'h55, 32'h55);
      chk({31'h0, result.pc_valid}, 32'h1);
      chk(result.next_pc, 32'h0000_0ff4);
      put(5'h01, 5'h02, 16'hfff0, OPC_BEQ, 32'h2000, 32'h55, 32'h54);
      chk(result.next_pc, 32'h0000_2004);
      put(5'h01, 5'h02, 16'h7ffc, OPC_BEQ, 32'h0, 32'h7, 32'h7);
      chk(result.next_pc, 32'h0000_8000);
      put(5'h01, 5'h02, 16'h0004, OPC_BEQ, 32'h3002, 32'h9, 32'h9);
      chk({31'h0, result.misalign_exc}, 32'h1);
      chk(result.bad_addr, 32'h0000_300a);
      chk({31'h0, result.pc_valid}, 32'h0);
      chk(result.next_pc, 32'h0000_8000);
      idle();
      chk({31'h0, result.misalign_exc}, 32'h0);
      put(5'h01, 5'h02, 16'h0004, OPC_BEQ, 32'h3002, 32'h9, 32'h8);
      chk({30'h0, result.pc_valid, result.misalign_exc}, 32'h2);
      chk(result.next_pc, 32'h0000_3006);
      $display("test_beq done");
   endtask : test_beq
   // Other opcode gives no write and no branch
   task automatic test_other();
      put(5'h01, 5'h02, 16'h0000, 6'h04, 32'h0, 32'h1, 32'h1);
      chk({30'h0, result.wr_en, result.pc_valid}, 32'h0);
      chk(result.next_pc, 32'h0000_3006);
      idle();
      $display("test_other done");
   endtask : test_other
   // Mid-run reset clears outputs, first issue right after release
   task automatic test_reset();
      rst_b = 1'b0;
      #1;
      chk(result.next_pc, PC_RESET);
      @(posedge clk);
      #1;
      rst_b = 1'b1;
      put(5'h02, 5'h05, 16'h00ff, OPC_ANDI, 32'h0, 32'h1234_5678, 32'h0);
      chk(result.wr_data, 32'h0000_0078);
      chk({27'h0, result.wr_idx}, 32'h05);
      $display("test_reset done");
   endtask : test_reset
   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // Reset, then run each scenario
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_b = 1'b1;
      chk(result.next_pc, PC_RESET);
      chk({30'h0, result.wr_en, result.pc_valid}, 32'h0);
      chk({31'h0, result.misalign_exc}, 32'h0);
      test_and();
      test_beq();
      test_other();
      test_reset();
      final_report();
   end
endmodule : and_imm_branch_eq_exec_tb_top
